// >>> pkg/bsmc_pkg.sv
// Purpose: Shared constants and types for the brown-out supply monitor control
// Assumes: 20 MHz system clock, fuse word presented during reset
// Notes:   Functional notes below
// Functional notes
// R1 - Threshold, active mode and sleep mode load from fuses during reset.
// R2 - Active/idle mode comes only from fuses; software cannot change it.
// R3 - Deep-sleep mode starts from fuses; software may rewrite it when unlocked.
// R4 - Monitor supports disabled, continuous and sampled operation.
// R5 - Supply below threshold with monitor enabled requests a system reset.
// R6 - Setting warning enable turns on the early-warning monitor; the code also needs a nonzero warning level field.
// R7 - Trigger config field selects falling, rising or either crossing.
// R8 - Warning monitor stays off while the brown-out monitor is disabled.
// R9 - In sampled mode the warning monitor evaluates only at sample instants.
// R10 - Enabling warning always sets flag in either-direction mode; may otherwise.
// R11 - Warning level field picks a percentage step above the threshold.
// R12 - A configured warning condition sets the warning flag.
// R13 - Interrupt request while enable and flag set, until flag cleared.
// R14 - Warning interrupt not serviced while the processor is debug-halted.
// R15 - Entering standby or power-down uses the deep-sleep mode field.
// R16 - Waking from standby or power-down returns to the active mode field.
// R17 - Software writes key then protected bits within four instructions.
// R18 - Protected write without valid unlock leaves contents unchanged.
// R19 - Only deep-sleep mode and sample-rate bit are protected, I/O key.
// R20 - Mode code 0 off, 1 continuous, 2 sampled, 3 continuous with stall.
// R21 - Trigger code 0 falling, 1 rising, 2 either, others reserved.
// R22 - Warning flag updates only while the brown-out monitor is enabled.
// R23 - Sample-rate bit 0 gives 128 Hz, 1 gives 32 Hz.
// R24 - Comparator outputs are synchronised before use.
// R25 - Writing one to the warning flag clears it; zero does nothing.
package bsmc_pkg;
	localparam int unsigned CLK_HZ        = 20000000;
	localparam int unsigned RATE_FAST_HZ  = 128;
	localparam int unsigned RATE_SLOW_HZ  = 32;
	localparam int unsigned PERIOD_FAST   = CLK_HZ / RATE_FAST_HZ;
	localparam int unsigned PERIOD_SLOW   = CLK_HZ / RATE_SLOW_HZ;
	localparam int unsigned SAMPLE_ON_NS  = 1000;
	localparam int unsigned SAMPLE_ON_CYC = (SAMPLE_ON_NS * (CLK_HZ / 1000000) + 999) / 1000;
	localparam int unsigned CNT_W         = 20;

	localparam logic [1:0] MODE_OFF   = 2'h0;
	localparam logic [1:0] MODE_CONT  = 2'h1;
	localparam logic [1:0] MODE_SAMP  = 2'h2;
	localparam logic [1:0] MODE_STALL = 2'h3;

	localparam logic [1:0] TRIG_FALL  = 2'h0;
	localparam logic [1:0] TRIG_RISE  = 2'h1;
	localparam logic [1:0] TRIG_BOTH  = 2'h2;

	localparam logic [1:0] SLEEP_RST  = 2'h0;
	localparam logic [1:0] TRIG_RST   = 2'h0;
	localparam logic [1:0] LEVEL_RST  = 2'h0;
	localparam logic [2:0] THRESH_RST = 3'h0;
	localparam logic [1:0] ACTIVE_RST = 2'h0;

	localparam int unsigned F_SLEEP_LSB  = 0;
	localparam int unsigned F_ACTIVE_LSB = 2;
	localparam int unsigned F_RATE_BIT   = 4;
	localparam int unsigned F_LVL_LSB    = 5;

	typedef struct packed {
		logic [2:0] threshold;
		logic       sample_rate_sel;
		logic [1:0] active_mode;
		logic [1:0] sleep_mode;
	} bsmc_fuse_t;

	typedef struct packed {
		logic       warning_irq_enable;
		logic [1:0] warning_trigger_cfg;
		logic [1:0] warning_level_sel;
	} bsmc_warn_cfg_t;
endpackage

// >>> src/bsmc_top.sv
// Purpose: Mode selection, reset request and warning flag for the supply monitor
// Assumes: Comparators are asynchronous; fuse word stable during reset
// Notes:   Control bits are plain ports, writes are one-cycle strobes
`timescale 1ns/10ps
module bsmc_top (
	input  wire logic                     clk,
	input  wire logic                     rstn,
	input  wire bsmc_pkg::bsmc_fuse_t     monitor_fuse_config,
	input  wire logic                     sleep_deep,
	input  wire logic                     debug_halt,
	input  wire logic                     cmp_below_thresh,
	input  wire logic                     cmp_below_warn,
	input  wire logic                     io_register_key,
	input  wire logic                     ctrl_wr,
	input  wire logic [1:0]               ctrl_sleep_wdata,
	input  wire logic                     ctrl_rate_wdata,
	input  wire logic                     warn_cfg_wr,
	input  wire bsmc_pkg::bsmc_warn_cfg_t warn_cfg_wdata,
	input  wire logic                     flag_clr_wr,
	output logic [2:0]                    threshold_q,
	output logic [1:0]                    active_mode_q,
	output logic [1:0]                    sleep_mode_q,
	output logic                          sample_rate_sel_q,
	output bsmc_pkg::bsmc_warn_cfg_t      warn_cfg_q,
	output logic [1:0]                    monitor_mode_q,
	output logic                          monitor_power_q,
	output logic                          warn_power_q,
	output logic                          stall_wake_q,
	output logic                          sys_reset_req_q,
	output logic                          warning_irq_flag_q,
	output logic                          warning_status_q,
	output logic                          irq_q
);
	localparam int unsigned CNT_W = bsmc_pkg::CNT_W;
	logic              fuse_load_q;
	logic [2:0]        sync_thr_q;
	logic [2:0]        sync_warn_q;
	logic              thr_low_q;
	logic              warn_low_q;
	logic              warn_prev_q;
	logic              warn_valid_q;
	logic [3:0]        unlock_q;
	logic [CNT_W-1:0]  period_cnt_q;
	logic [7:0]        on_cnt_q;
	logic              sample_tick;
	logic              enabled;
	logic              warn_active;
	logic              ie_rise;
	logic              crossing;
	logic [1:0]        mode_d;

	// Fuse load at reset release
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			fuse_load_q <= 1'b1;
		end else begin
			fuse_load_q <= 1'b0;
		end
	end

	// Threshold and active mode, fuse only
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			threshold_q   <= bsmc_pkg::THRESH_RST;
			active_mode_q <= bsmc_pkg::ACTIVE_RST;
		end else if (fuse_load_q) begin
			threshold_q   <= monitor_fuse_config.threshold; // R1 R2
			active_mode_q <= monitor_fuse_config.active_mode; // R1 R2
		end
	end

	// Unlock window counts four cycles after the key
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			unlock_q <= 4'h0;
		end else if (io_register_key) begin
			unlock_q <= 4'h4; // R17 R19
		end else if (unlock_q != 4'h0) begin
			unlock_q <= unlock_q - 4'h1;
		end
	end

	// Protected sleep mode and sample rate
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			sleep_mode_q      <= bsmc_pkg::SLEEP_RST;
			sample_rate_sel_q <= 1'b0;
		end else if (fuse_load_q) begin
			sleep_mode_q      <= monitor_fuse_config.sleep_mode; // R1 R3
			sample_rate_sel_q <= monitor_fuse_config.sample_rate_sel;
		end else if (ctrl_wr && unlock_q != 4'h0) begin
			sleep_mode_q      <= ctrl_sleep_wdata; // R3 R18 R19
			sample_rate_sel_q <= ctrl_rate_wdata; // R19
		end
	end

	// Warning configuration, unprotected
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			warn_cfg_q <= '0;
		end else if (warn_cfg_wr) begin
			warn_cfg_q <= warn_cfg_wdata; // R6 R7 R11
		end
	end

	// Operating mode follows sleep state
	always_comb begin
		mode_d = sleep_deep ? sleep_mode_q : active_mode_q; // R15 R16
		if (sleep_deep && sleep_mode_q == bsmc_pkg::MODE_STALL) begin
			mode_d = bsmc_pkg::MODE_OFF;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			monitor_mode_q <= bsmc_pkg::MODE_OFF;
			stall_wake_q   <= 1'b0;
		end else begin
			monitor_mode_q <= fuse_load_q ? bsmc_pkg::MODE_OFF : mode_d; // R4 R15 R16 R20
			stall_wake_q   <= !sleep_deep && monitor_mode_q == bsmc_pkg::MODE_OFF &&
				mode_d == bsmc_pkg::MODE_STALL; // R20
		end
	end

	assign enabled = monitor_mode_q != bsmc_pkg::MODE_OFF;

	// Sample period and on-window counters
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			period_cnt_q <= '0;
		end else if (monitor_mode_q != bsmc_pkg::MODE_SAMP || period_cnt_q == '0) begin
			period_cnt_q <= sample_rate_sel_q ? CNT_W'(bsmc_pkg::PERIOD_SLOW - 1) :
				CNT_W'(bsmc_pkg::PERIOD_FAST - 1); // R23
		end else begin
			period_cnt_q <= period_cnt_q - 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			on_cnt_q <= 8'h0;
		end else if (monitor_mode_q == bsmc_pkg::MODE_SAMP && period_cnt_q == '0) begin
			on_cnt_q <= 8'(bsmc_pkg::SAMPLE_ON_CYC + 3); // R9
		end else if (on_cnt_q != 8'h0) begin
			on_cnt_q <= on_cnt_q - 8'h1;
		end
	end

	assign sample_tick = (monitor_mode_q == bsmc_pkg::MODE_SAMP) ? (on_cnt_q == 8'h1) : enabled; // R4 R9

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			monitor_power_q <= 1'b0;
			warn_power_q    <= 1'b0;
		end else begin
			monitor_power_q <= (monitor_mode_q == bsmc_pkg::MODE_SAMP) ? (on_cnt_q > 8'h1) : enabled;
			warn_power_q    <= warn_active && ((monitor_mode_q == bsmc_pkg::MODE_SAMP) ?
				(on_cnt_q > 8'h1) : 1'b1); // R8 R9
		end
	end

	// Comparator synchronisers
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			sync_thr_q  <= 3'h0;
			sync_warn_q <= 3'h0;
		end else begin
			sync_thr_q  <= {sync_thr_q[1:0], cmp_below_thresh}; // R24
			sync_warn_q <= {sync_warn_q[1:0], cmp_below_warn}; // R24
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			thr_low_q  <= 1'b0;
			warn_low_q <= 1'b0;
		end else begin
			if (sync_thr_q[2] == sync_thr_q[1]) begin
				thr_low_q <= sync_thr_q[2]; // R24
			end
			if (sync_warn_q[2] == sync_warn_q[1]) begin
				warn_low_q <= sync_warn_q[2]; // R24
			end
		end
	end

	// System reset request
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			sys_reset_req_q <= 1'b0;
		end else begin
			sys_reset_req_q <= enabled && sample_tick && thr_low_q; // R5
		end
	end

	// Warning evaluation
	assign warn_active = enabled && warn_cfg_q.warning_irq_enable &&
		warn_cfg_q.warning_level_sel != 2'h0; // R6 R8 R11

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			warn_prev_q      <= 1'b0;
			warn_valid_q     <= 1'b0;
			warning_status_q <= 1'b0;
		end else if (!warn_active) begin
			warn_valid_q <= 1'b0; // R8
		end else if (sample_tick) begin
			warn_prev_q      <= warn_low_q; // R9
			warn_valid_q     <= 1'b1;
			warning_status_q <= warn_low_q;
		end
	end

	assign ie_rise = warn_active && !warn_valid_q && sample_tick;

	always_comb begin
		case (warn_cfg_q.warning_trigger_cfg)
			bsmc_pkg::TRIG_FALL: crossing = warn_low_q && !warn_prev_q; // R21
			bsmc_pkg::TRIG_RISE: crossing = !warn_low_q && warn_prev_q; // R21
			bsmc_pkg::TRIG_BOTH: crossing = warn_low_q != warn_prev_q; // R21
			default:             crossing = 1'b0;
		endcase
	end

	// Warning flag, set wins over clear
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			warning_irq_flag_q <= 1'b0;
		end else if (enabled && sample_tick && ((warn_valid_q && crossing) ||
			(ie_rise && warn_cfg_q.warning_trigger_cfg == bsmc_pkg::TRIG_BOTH))) begin
			warning_irq_flag_q <= 1'b1; // R7 R10 R12 R22
		end else if (flag_clr_wr) begin
			warning_irq_flag_q <= 1'b0; // R25
		end
	end

	// Interrupt request
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= warn_cfg_q.warning_irq_enable && warning_irq_flag_q && !debug_halt; // R13 R14
		end
	end

	property p_fuse_load;
		@(posedge clk) disable iff (!rstn)
		rstn && fuse_load_q |=> threshold_q == $past(monitor_fuse_config.threshold) &&
			active_mode_q == $past(monitor_fuse_config.active_mode);
	endproperty
	a_fuse_load: assert property (p_fuse_load) else $error("fuse values not loaded"); // R1

	property p_active_fixed;
		@(posedge clk) disable iff (!rstn)
		!fuse_load_q |=> $stable(active_mode_q) && $stable(threshold_q);
	endproperty
	a_active_fixed: assert property (p_active_fixed) else $error("active mode changed"); // R2

	property p_locked;
		@(posedge clk) disable iff (!rstn)
		ctrl_wr && unlock_q == 4'h0 && !fuse_load_q |=> $stable(sleep_mode_q) && $stable(sample_rate_sel_q);
	endproperty
	a_locked: assert property (p_locked) else $error("protected write without unlock"); // R18

	sequence s_key;
		io_register_key ##1 !io_register_key [*3];
	endsequence
	property p_unlocked_write;
		@(posedge clk) disable iff (!rstn)
		s_key ##1 (ctrl_wr && !io_register_key) |=> sleep_mode_q == $past(ctrl_sleep_wdata);
	endproperty
	a_unlocked_write: assert property (p_unlocked_write) else $error("unlocked write lost"); // R3

	property p_mode_select;
		@(posedge clk) disable iff (!rstn)
		!fuse_load_q |=> monitor_mode_q == $past(mode_d);
	endproperty
	a_mode_select: assert property (p_mode_select) else $error("wrong operating mode"); // R15

	property p_reset_req;
		@(posedge clk) disable iff (!rstn)
		sys_reset_req_q |-> $past(thr_low_q) && $past(enabled);
	endproperty
	a_reset_req: assert property (p_reset_req) else $error("spurious reset request"); // R5

	property p_flag_off;
		@(posedge clk) disable iff (!rstn)
		!enabled && !warning_irq_flag_q |=> !warning_irq_flag_q;
	endproperty
	a_flag_off: assert property (p_flag_off) else $error("flag set while disabled"); // R22

	property p_irq;
		@(posedge clk) disable iff (!rstn)
		warn_cfg_q.warning_irq_enable && warning_irq_flag_q && !debug_halt |=> irq_q;
	endproperty
	a_irq: assert property (p_irq) else $error("interrupt not raised"); // R13

	property p_debug;
		@(posedge clk) disable iff (!rstn)
		debug_halt |=> !irq_q;
	endproperty
	a_debug: assert property (p_debug) else $error("interrupt during debug halt"); // R14
endmodule

// >>> verification/bsmc_supply_model.sv
// Purpose: Stand-in for the analogue supply comparators
// Assumes: Command inputs tell whether the supply sits below each level
// Notes:   An unpowered comparator gives a toggling, meaningless output
`timescale 1ns/10ps
module bsmc_supply_model (
	input  wire logic clk,
	input  wire logic below_bod,
	input  wire logic below_warn,
	input  wire logic bod_power,
	input  wire logic warn_power,
	output logic      cmp_below_thresh,
	output logic      cmp_below_warn
);
	logic junk_q = 1'b0;

	// Changes every cycle so an unpowered output is never stable
	always @(posedge clk) begin
		junk_q <= ~junk_q;
	end

	// Comparators are unclocked, so outputs move off the clock edge
	assign #3 cmp_below_thresh = bod_power ? below_bod : junk_q;
	assign #3 cmp_below_warn   = warn_power ? below_warn : junk_q;
endmodule

// >>> verification/test_brownout_supply_monitor_ctrl.sv
// Purpose: Self-checking bench for the supply monitor control
// Assumes: Sampled periods are too long to reach a sample instant
// Notes:   Protected writes run from a table, except one in the second reset test; the rest by hand
`timescale 1ns/10ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin n_mismatch++; $display("[ERR] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module test_brownout_supply_monitor_ctrl;
	typedef struct {
		int         gap;
		logic [1:0] sl;
		logic       rt;
		logic [1:0] exp_sl;
		logic       exp_rt;
	} bsmc_row_t;

	logic                     clk, rstn, sleep_deep, debug_halt, below_bod, below_warn;
	logic                     io_register_key, ctrl_wr, ctrl_rate_wdata, warn_cfg_wr, flag_clr_wr;
	logic [1:0]               ctrl_sleep_wdata;
	bsmc_pkg::bsmc_fuse_t     fuse;
	bsmc_pkg::bsmc_warn_cfg_t warn_cfg_wdata, warn_cfg_q;
	logic                     cmp_below_thresh, cmp_below_warn, sample_rate_sel_q;
	logic [2:0]               threshold_q;
	logic [1:0]               active_mode_q, sleep_mode_q, monitor_mode_q;
	logic                     monitor_power_q, warn_power_q, sys_reset_req_q, stall_wake_q;
	logic                     warning_irq_flag_q, warning_status_q, irq_q;
	int                       n_mismatch, checks_done;
	bsmc_row_t                rows [5];

	bsmc_top i_bsmc_top (.clk(clk), .rstn(rstn), .monitor_fuse_config(fuse), .sleep_deep(sleep_deep),
		.debug_halt(debug_halt), .cmp_below_thresh(cmp_below_thresh), .cmp_below_warn(cmp_below_warn),
		.io_register_key(io_register_key), .ctrl_wr(ctrl_wr), .ctrl_sleep_wdata(ctrl_sleep_wdata),
		.ctrl_rate_wdata(ctrl_rate_wdata), .warn_cfg_wr(warn_cfg_wr), .warn_cfg_wdata(warn_cfg_wdata),
		.flag_clr_wr(flag_clr_wr), .threshold_q(threshold_q), .active_mode_q(active_mode_q),
		.sleep_mode_q(sleep_mode_q), .sample_rate_sel_q(sample_rate_sel_q), .warn_cfg_q(warn_cfg_q),
		.monitor_mode_q(monitor_mode_q), .monitor_power_q(monitor_power_q), .warn_power_q(warn_power_q),
		.stall_wake_q(stall_wake_q), .sys_reset_req_q(sys_reset_req_q), .warning_irq_flag_q(warning_irq_flag_q),
		.warning_status_q(warning_status_q), .irq_q(irq_q));

	bsmc_supply_model i_bsmc_supply_model (.clk(clk), .below_bod(below_bod), .below_warn(below_warn),
		.bod_power(monitor_power_q), .warn_power(warn_power_q), .cmp_below_thresh(cmp_below_thresh),
		.cmp_below_warn(cmp_below_warn));

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask

	task automatic complete_run;
		$display("checks_done=%0d n_mismatch=%0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// Key pulse, then a protected write gap cycles later
	task automatic prot_wr(input int gap, input logic [1:0] sl, input logic rt);
		@(posedge clk);
		ctrl_sleep_wdata <= sl;
		ctrl_rate_wdata  <= rt;
		io_register_key  <= 1'b1;
		ctrl_wr          <= (gap == 0);
		for (int i = 1; i <= gap; i++) begin
			@(posedge clk);
			io_register_key <= 1'b0;
			ctrl_wr         <= (i == gap);
		end
		@(posedge clk);
		io_register_key <= 1'b0;
		ctrl_wr         <= 1'b0;
	endtask

	task automatic wr_cfg(input logic en, input logic [1:0] trig);
		@(posedge clk);
		warn_cfg_wdata <= '{warning_irq_enable: en, warning_trigger_cfg: trig, warning_level_sel: 2'h1};
		warn_cfg_wr    <= 1'b1;
		@(posedge clk);
		warn_cfg_wr <= 1'b0;
	endtask

	task automatic clr_flag;
		@(posedge clk);
		flag_clr_wr <= 1'b1;
		@(posedge clk);
		flag_clr_wr <= 1'b0;
	endtask

	initial begin
		#(20000 * 50);
		n_mismatch++;
		$display("watchdog expired");
		complete_run;
	end

	initial begin
		n_mismatch = 0;
		checks_done = 0;
		{rstn, sleep_deep, debug_halt, below_bod, below_warn, io_register_key} = 6'h00;
		{ctrl_wr, ctrl_rate_wdata, warn_cfg_wr, flag_clr_wr, ctrl_sleep_wdata} = 6'h00;
		warn_cfg_wdata = '0;
		fuse = '{threshold: 3'h2, sample_rate_sel: 1'b1, active_mode: bsmc_pkg::MODE_CONT,
			sleep_mode: bsmc_pkg::MODE_OFF};
		rows = '{'{0, 2'h1, 1'b0, 2'h0, 1'b1}, '{1, 2'h1, 1'b0, 2'h1, 1'b0}, '{4, 2'h2, 1'b1, 2'h2, 1'b1},
			'{5, 2'h1, 1'b0, 2'h2, 1'b1}, '{2, 2'h0, 1'b1, 2'h0, 1'b1}};
		cyc(10);
		`CHK(sys_reset_req_q, 1'b0)
		`CHK(irq_q, 1'b0)
		@(posedge clk);
		rstn <= 1'b1;
		cyc(3);
		`CHK(threshold_q, fuse.threshold)
		`CHK(active_mode_q, fuse.active_mode)
		`CHK(sleep_mode_q, fuse.sleep_mode)
		`CHK(sample_rate_sel_q, fuse.sample_rate_sel)
		`CHK(monitor_mode_q, bsmc_pkg::MODE_CONT)
		$display("test reset done");
		foreach (rows[k]) begin
			prot_wr(rows[k].gap, rows[k].sl, rows[k].rt);
			cyc(6);
			`CHK(sleep_mode_q, rows[k].exp_sl)
			`CHK(sample_rate_sel_q, rows[k].exp_rt)
			`CHK(active_mode_q, fuse.active_mode)
		end
		$display("test protected writes done");
		below_bod <= 1'b1;
		cyc(10);
		`CHK(sys_reset_req_q, 1'b1)
		below_bod <= 1'b0;
		cyc(10);
		`CHK(sys_reset_req_q, 1'b0)
		$display("test brownout done");
		sleep_deep <= 1'b1;
		cyc(6);
		`CHK(monitor_mode_q, bsmc_pkg::MODE_OFF)
		below_bod <= 1'b1;
		wr_cfg(1'b1, bsmc_pkg::TRIG_BOTH);
		cyc(10);
		`CHK(sys_reset_req_q, 1'b0)
		`CHK(warning_irq_flag_q, 1'b0)
		`CHK(warn_power_q, 1'b0)
		sleep_deep <= 1'b0;
		cyc(10);
		`CHK(monitor_mode_q, bsmc_pkg::MODE_CONT)
		`CHK(sys_reset_req_q, 1'b1)
		below_bod <= 1'b0;
		wr_cfg(1'b0, bsmc_pkg::TRIG_FALL);
		clr_flag();
		cyc(10);
		$display("test sleep done");
		for (int t = 0; t < 3; t++) begin
			wr_cfg(1'b1, 2'(t));
			cyc(10);
			`CHK(warn_cfg_q.warning_trigger_cfg, 2'(t))
			`CHK(warn_cfg_q.warning_irq_enable, 1'b1)
			if (t == 2) begin
				`CHK(warning_irq_flag_q, 1'b1)
				`CHK(irq_q, 1'b1)
				debug_halt <= 1'b1;
				cyc(3);
				`CHK(irq_q, 1'b0)
				debug_halt <= 1'b0;
				cyc(3);
				`CHK(irq_q, 1'b1)
			end
			clr_flag();
			cyc(4);
			`CHK(warning_irq_flag_q, 1'b0)
			below_warn <= 1'b1;
			cyc(10);
			`CHK(warning_status_q, 1'b1)
			`CHK(warning_irq_flag_q, (t != 1))
			`CHK(irq_q, (t != 1))
			clr_flag();
			below_warn <= 1'b0;
			cyc(10);
			`CHK(warning_irq_flag_q, (t != 0))
			clr_flag();
			wr_cfg(1'b0, 2'(t));
			cyc(4);
		end
		$display("test warning triggers done");
		rstn      <= 1'b0;
		below_bod <= 1'b1;
		fuse      <= '{threshold: 3'h5, sample_rate_sel: 1'b0, active_mode: bsmc_pkg::MODE_STALL,
			sleep_mode: bsmc_pkg::MODE_SAMP};
		cyc(3);
		`CHK(threshold_q, bsmc_pkg::THRESH_RST)
		`CHK(sys_reset_req_q, 1'b0)
		rstn <= 1'b1;
		cyc(3);
		`CHK(threshold_q, fuse.threshold)
		`CHK(sleep_mode_q, bsmc_pkg::MODE_SAMP)
		`CHK(monitor_mode_q, bsmc_pkg::MODE_STALL)
		`CHK(stall_wake_q, 1'b1)
		cyc(1);
		`CHK(stall_wake_q, 1'b0)
		sleep_deep <= 1'b1;
		cyc(10);
		`CHK(monitor_mode_q, bsmc_pkg::MODE_SAMP)
		`CHK(monitor_power_q, 1'b0)
		`CHK(sys_reset_req_q, 1'b0)
		sleep_deep <= 1'b0;
		cyc(4);
		`CHK(monitor_mode_q, bsmc_pkg::MODE_STALL)
		`CHK(stall_wake_q, 1'b0)
		`CHK(sys_reset_req_q, 1'b1)
		below_bod <= 1'b0;
		prot_wr(1, bsmc_pkg::MODE_OFF, 1'b0);
		sleep_deep <= 1'b1;
		cyc(4);
		`CHK(monitor_mode_q, bsmc_pkg::MODE_OFF)
		sleep_deep <= 1'b0;
		cyc(2);
		`CHK(stall_wake_q, 1'b1)
		`CHK(monitor_mode_q, bsmc_pkg::MODE_STALL)
		cyc(1);
		`CHK(stall_wake_q, 1'b0)
		$display("test second reset done");
		warn_cfg_wdata <= '{warning_irq_enable: 1'b1, warning_trigger_cfg: bsmc_pkg::TRIG_BOTH,
			warning_level_sel: 2'h0};
		warn_cfg_wr    <= 1'b1;
		cyc(1);
		warn_cfg_wr <= 1'b0;
		cyc(6);
		`CHK(warning_irq_flag_q, 1'b0)
		`CHK(warn_power_q, 1'b0)
		wr_cfg(1'b1, 2'h3);
		below_warn <= 1'b1;
		cyc(10);
		`CHK(warning_status_q, 1'b1)
		`CHK(warning_irq_flag_q, 1'b0)
		$display("test reserved codes done");
		complete_run;
	end
endmodule
